// ==== include/cantrx_pkg.sv ====
// Purpose : Shared constants and types for the CAN transceiver mode and wake block
// Assumes : 100 MHz system clock
// Notes   : Times are kept in their own unit; cycle counts derive from them
package cantrx_pkg;

  // =====================================================================
  // Clock and timing
  // =====================================================================
  localparam int CLK_MHZ           = 100;
  localparam int TXD_DOM_TIMEOUT_US = 300;
  localparam int TXD_DOM_CYC        = TXD_DOM_TIMEOUT_US * CLK_MHZ;       // Least time, exact
  localparam int WAKE_PULSE_MIN_NS  = 500;
  localparam int WAKE_PULSE_MIN_CYC = (WAKE_PULSE_MIN_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int WAKE_WINDOW_US     = 120;
  localparam int WAKE_WINDOW_CYC    = WAKE_WINDOW_US * CLK_MHZ;           // Longest time
  localparam int WAKE_SINGLE_NS     = 2000;
  localparam int WAKE_SINGLE_CYC    = (WAKE_SINGLE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_PULSES        = 3;

  // =====================================================================
  // Register map (word offsets on the plain port)
  // =====================================================================
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ    = 4'h2;
  localparam logic [3:0] REG_MASK   = 4'h3;

  // CTRL fields
  localparam int CTRL_MODE_LSB   = 0;  // [1:0] transceiver mode
  localparam int CTRL_SLEW_LSB   = 2;  // [3:2] slew selection
  localparam int CTRL_WAKE_EN    = 4;
  localparam int CTRL_SINGLE_SEL = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // IRQ / MASK bit positions
  localparam int IRQ_WAKE    = 0;
  localparam int IRQ_TXD_DOM = 1;
  localparam int IRQ_W       = 2;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // =====================================================================
  // Types
  // =====================================================================
  typedef enum logic [1:0] {
    CANTRX_SLEEP   = 2'b00,
    CANTRX_NORMAL  = 2'b01,
    CANTRX_RX_ONLY = 2'b10
  } cantrx_mode_t;

  typedef enum logic [1:0] {
    CANTRX_SLEW_FAST = 2'b00,
    CANTRX_SLEW_MID  = 2'b01,
    CANTRX_SLEW_SLOW = 2'b10
  } cantrx_slew_t;

  // Bus-side drive outputs travel together
  typedef struct packed {
    logic drv_en;
    logic dominant;
    logic split_oe_n;
    logic term_gnd;
    cantrx_slew_t slew;
  } cantrx_bus_t;

endpackage

// ==== sim/cantrx_host.sv ====
// Purpose : Host protocol controller model driving the transmit pin
// Assumes : want_dom comes from the bench, synchronous to clk
// Notes   : One cycle from request to pin, like a registered output
`timescale 1ns/100ps
module cantrx_host
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench request and pin
  input  wire logic want_dom,
  output logic      txd
);
  // Recessive through reset, so the driver arms without a glitch
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      txd <= 1'b1;
    else
      txd <= !want_dom;
endmodule // cantrx_host

// ==== sim/tb_top.sv ====
// Purpose : Self-checking bench for the transceiver mode and wake block
// Assumes : Short counts: stuck limit 100 cycles, wake window 2000
// Notes   : Bus level is a wired model of our driver plus remote pulses
`timescale 1ns/100ps
module tb_top
  import cantrx_pkg::*;
;
  // ===================================================================
  // Signals
  // ===================================================================
  typedef struct packed {
    logic [7:0] ctrl;
    logic       dom;
    logic       ext;
    logic [7:0] exp;
  } cantrx_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        ce = 1'b1;
  logic        want_dom = 1'b0;
  logic        ext_dom = 1'b0;
  logic        txd;
  logic        rxd;
  logic        bus_dom_w;
  cantrx_bus_t bus_ctl;
  logic        low_power_state;
  logic        irq;
  logic [7:0]  rv;
  int          failures = 0;
  int          total_checks = 0;
  // Rows: control word, host request, remote pulse, {rxd, lp, bus_ctl}
  cantrx_row_t rows [5] = '{
    '{8'h01, 1'b0, 1'b0, 8'hA0},
    '{8'h05, 1'b1, 1'b0, 8'h31},
    '{8'h0A, 1'b1, 1'b0, 8'h82},
    '{8'h0F, 1'b0, 1'b1, 8'h00},
    '{8'h00, 1'b0, 1'b0, 8'hCC}};
  // Dominant wins on the wire
  assign bus_dom_w = ext_dom | (bus_ctl.drv_en & bus_ctl.dominant);
  initial
    forever #5 clk = ~clk;
  cantrx_host i_cantrx_host (.clk(clk), .rst_n(rst_n), .want_dom(want_dom), .txd(txd));
  cantrx_top #(.TXD_TIMEOUT_CYC(100), .WINDOW_CYC(2000)) i_cantrx_top (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd), .bus_dom(bus_dom_w),
    .bus_ctl(bus_ctl), .low_power_state(low_power_state), .irq(irq));
  // ===================================================================
  // Tasks
  // ===================================================================
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic pulse(input int w, input int gap);
    @(posedge clk);
    ext_dom <= 1'b1;
    repeat (w) @(posedge clk);
    ext_dom <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask
  // Bounded wait: wake must land within a few cycles of the pulse end
  task automatic wait_wake();
    int i;
    for (i = 0; i < 20 && low_power_state !== 1'b0; i++)
      @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ===================================================================
  // Watchdog, well past the roughly 9k cycles the tests take
  // ===================================================================
  initial
  begin
    #400_000;
    failures++;
    report_and_stop();
  end
  // ===================================================================
  // Tests
  // ===================================================================
  initial
  begin
    tk(1);
    chk({rxd, low_power_state, bus_ctl}, 8'hCC);
    chk({7'h00, irq}, 8'h00);
    chk(reg_rdata, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, rv);
    chk(rv, CTRL_RESET);
    rd(REG_MASK, rv);
    chk(rv, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, rv);
    chk(rv, 8'h00);
    rd(REG_STATUS, rv);
    chk(rv, 8'h04);
    // Clock enable low: a write in that cycle is lost
    @(posedge clk);
    ce <= 1'b0;
    wr(REG_MASK, 8'h03);
    ce <= 1'b1;
    rd(REG_MASK, rv);
    chk(rv, 8'h00);
    $display("reset test done");
    // Mode, slew, drive and receive table
    foreach (rows[k])
    begin
      @(posedge clk);
      want_dom <= rows[k].dom;
      ext_dom <= rows[k].ext;
      wr(REG_CTRL, rows[k].ctrl);
      tk(4);
      chk({rxd, low_power_state, bus_ctl}, rows[k].exp);
    end
    $display("table test done");
    // Transmit stuck dominant, interrupt mask and clear
    wr(REG_CTRL, 8'h01);
    wr(REG_MASK, 8'h02);
    tk(4);
    @(posedge clk);
    want_dom <= 1'b1;
    tk(80);
    chk({7'h00, bus_ctl.drv_en}, 8'h01);
    tk(50);
    chk({6'h00, bus_ctl.drv_en, irq}, 8'h01);
    rd(REG_STATUS, rv);
    chk(rv & 8'h08, 8'h08);
    wr(REG_MASK, 8'h00);
    tk(2);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    want_dom <= 1'b0;
    tk(5);
    chk({7'h00, bus_ctl.drv_en}, 8'h01);
    wr(REG_IRQ, 8'h02);
    rd(REG_IRQ, rv);
    chk(rv, 8'h00);
    $display("stuck test done");
    // Wake detection off, short pulses, window expiry, then a pattern
    wr(REG_CTRL, 8'h00);
    wr(REG_MASK, 8'h01);
    wr(REG_IRQ, 8'h03);
    repeat (3) pulse(60, 100);
    tk(5);
    chk({7'h00, low_power_state}, 8'h01);
    wr(REG_CTRL, 8'h10);
    repeat (3) pulse(50, 100);
    tk(5);
    chk({7'h00, low_power_state}, 8'h01);
    tk(2100);
    repeat (2) pulse(60, 100);
    tk(2100);
    pulse(60, 0);
    tk(5);
    chk({7'h00, low_power_state}, 8'h01);
    tk(2100);
    repeat (3) pulse(60, 100);
    wait_wake();
    chk({6'h00, low_power_state, irq}, 8'h01);
    rd(REG_IRQ, rv);
    chk(rv, 8'h01);
    tk(4);
    chk({rxd, low_power_state, bus_ctl}, 8'hA0);
    $display("pattern wake test done");
    // Single-pulse wake: too short, then long enough
    wr(REG_CTRL, 8'h30);
    wr(REG_IRQ, 8'h03);
    tk(4);
    pulse(150, 10);
    chk({7'h00, low_power_state}, 8'h01);
    pulse(210, 0);
    wait_wake();
    chk({6'h00, low_power_state, irq}, 8'h01);
    $display("single wake test done");
    // Reset in mid-run drops back to sleep with the bus released
    @(posedge clk);
    rst_n <= 1'b0;
    tk(2);
    chk({rxd, low_power_state, bus_ctl}, 8'hCC);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, rv);
    chk(rv, CTRL_RESET);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule // tb_top

// ==== src/cantrx_top.sv ====
// Purpose : CAN transceiver mode control, TXD timeout, slew, wake and interrupt
// Assumes : All inputs synchronous to clk; bus state given as a comparator level
// Notes   : Registers on a plain strobe port, read data one cycle after the strobe
`timescale 1ns/100ps

module cantrx_top
  import cantrx_pkg::*;
#(
  parameter int TXD_TIMEOUT_CYC = TXD_DOM_CYC,
  parameter int WINDOW_CYC      = WAKE_WINDOW_CYC
)
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Host side pins
  input  wire logic        txd,
  output logic             rxd,
  // Bus side
  input  wire logic        bus_dom,
  output cantrx_bus_t      bus_ctl,
  // System
  output logic             low_power_state,
  output logic             irq
);

  // =====================================================================
  // Registers
  // =====================================================================
  logic [7:0]      ctrl_q;
  logic [IRQ_W-1:0] irq_sts_q;
  logic [IRQ_W-1:0] mask_q;
  logic [7:0]      rdata_q;
  logic            armed_q;
  logic [24:0]     txd_cnt_q;
  logic            txd_dom_q;
  logic            rxd_q;
  logic            irq_q;
  logic            lp_q;
  cantrx_bus_t     bus_q;
  logic            wake_pulse;

  // Field decode
  wire cantrx_mode_t mode_raw = cantrx_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  wire cantrx_slew_t slew_raw = cantrx_slew_t'(ctrl_q[CTRL_SLEW_LSB +: 2]);
  wire is_sleep   = (mode_raw == CANTRX_SLEEP);
  wire is_normal  = (mode_raw == CANTRX_NORMAL);
  wire is_rx_only = !is_sleep && !is_normal;
  wire wake_en    = ctrl_q[CTRL_WAKE_EN];
  wire single_sel = ctrl_q[CTRL_SINGLE_SEL];

  // Register decode
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire wr_irq  = reg_wr && (reg_addr == REG_IRQ);
  wire wr_mask = reg_wr && (reg_addr == REG_MASK);

  // Unmapped addresses read as zero
  wire [7:0] rd_mux =
    (reg_addr == REG_CTRL)   ? ctrl_q :
    (reg_addr == REG_STATUS) ? {4'h0, txd_dom_q, lp_q, armed_q, bus_dom} :
    (reg_addr == REG_IRQ)    ? {6'h00, irq_sts_q} :
    (reg_addr == REG_MASK)   ? {6'h00, mask_q} : 8'h00;

  // =====================================================================
  // Control register and low-power state
  // =====================================================================
  // Wake forces the mode back to normal so the device leaves low power
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= CTRL_RESET;
    else if (ce)
    begin
      if (wake_pulse)
        ctrl_q[CTRL_MODE_LSB +: 2] <= CANTRX_NORMAL;
      else if (wr_ctrl)
        ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lp_q <= 1'b1;
    else if (ce)
      lp_q <= is_sleep && !wake_pulse;
  end

  // =====================================================================
  // Driver arming and transmit stuck-dominant detection
  // =====================================================================
  // Arming waits for a recessive transmit level so a stuck low never glitches the bus
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed_q <= 1'b0;
    else if (ce)
    begin
      if (!is_normal)
        armed_q <= 1'b0;
      else if (txd)
        armed_q <= 1'b1;
    end
  end

  wire txd_cnt_hit = (txd_cnt_q >= 25'(TXD_TIMEOUT_CYC - 1));

  // Timeout latches off the driver until transmit returns high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txd_cnt_q <= 25'h0;
      txd_dom_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!is_normal || txd)
      begin
        txd_cnt_q <= 25'h0;
        txd_dom_q <= 1'b0;
      end
      else if (txd_cnt_hit)
        txd_dom_q <= 1'b1;
      else
        txd_cnt_q <= txd_cnt_q + 25'h1;
    end
  end

  // =====================================================================
  // Bus outputs and receive pin
  // =====================================================================
  wire drv_on = is_normal && armed_q && !txd_dom_q;
  wire cantrx_bus_t bus_d = '{
    drv_en:     drv_on,
    dominant:   drv_on && !txd,
    split_oe_n: is_sleep,
    term_gnd:   is_sleep,
    slew:       (slew_raw == 2'b11) ? CANTRX_SLEW_FAST : slew_raw
  };

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_q <= '{drv_en: 1'b0, dominant: 1'b0, split_oe_n: 1'b1,
                 term_gnd: 1'b1, slew: CANTRX_SLEW_FAST};
      rxd_q <= 1'b1;
    end
    else if (ce)
    begin
      bus_q <= bus_d;
      rxd_q <= is_sleep ? 1'b1 : !bus_dom;
    end
  end

  // =====================================================================
  // Wake detector
  // =====================================================================
  cantrx_wake #(
    .WINDOW_CYC (WINDOW_CYC)
  ) u_wake (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .enable     (wake_en && is_sleep),
    .single_sel (single_sel),
    .bus_dom    (bus_dom),
    .wake_pulse (wake_pulse)
  );

  // =====================================================================
  // Interrupt status, mask and read port
  // =====================================================================
  wire [IRQ_W-1:0] irq_set = {txd_cnt_hit && !txd_dom_q && is_normal && !txd, wake_pulse};
  wire [IRQ_W-1:0] irq_clr = wr_irq ? reg_wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_nxt = (irq_sts_q & ~irq_clr) | irq_set;

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_sts_q <= '0;
      mask_q    <= MASK_RESET;
      irq_q     <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else if (ce)
    begin
      irq_sts_q <= irq_nxt;
      if (wr_mask)
        mask_q <= reg_wdata[IRQ_W-1:0];
      irq_q   <= |(irq_nxt & (wr_mask ? reg_wdata[IRQ_W-1:0] : mask_q));
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata       = rdata_q;
  assign rxd             = rxd_q;
  assign bus_ctl         = bus_q;
  assign low_power_state = lp_q;
  assign irq             = irq_q;

  // =====================================================================
  // Checks
  // =====================================================================
  a_drv_needs_normal: assert property (@(posedge clk) disable iff (!rst_n)
    bus_ctl.drv_en |-> $past(is_normal) && $past(armed_q))
    else $error("driver enabled outside armed normal mode");

  a_txd_low_dom: assert property (@(posedge clk) disable iff (!rst_n)
    ce && drv_on && !txd |=> bus_ctl.dominant)
    else $error("transmit low did not drive dominant");

  a_txd_high_rec: assert property (@(posedge clk) disable iff (!rst_n)
    ce && txd |=> !bus_ctl.dominant)
    else $error("transmit high not recessive");

  a_rxd_follows_bus: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !is_sleep |=> rxd == !$past(bus_dom))
    else $error("receive pin not tracking bus");

  a_rx_only_off: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_rx_only |=> !bus_ctl.drv_en)
    else $error("driver on in receive-only");

  a_sleep_bias: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_sleep |=> bus_ctl.split_oe_n && bus_ctl.term_gnd && !bus_ctl.drv_en)
    else $error("sleep bias or termination wrong");

  a_wake_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wake_pulse |=> irq_sts_q[IRQ_WAKE] && !low_power_state)
    else $error("wake flag not set");

  a_txd_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    ce && txd_dom_q |=> !bus_ctl.drv_en)
    else $error("driver on after stuck dominant");

  a_wake_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
    wake_pulse |-> $past(wake_en))
    else $error("wake without enable");

  // =====================================================================
  // Checks on arming, bias and slew
  // =====================================================================
  // A low transmit level must never arm the driver, or the bus would glitch
  a_arm_waits_txd: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_normal && !armed_q && !txd |=> !armed_q)
    else $error("driver armed while transmit low");

  // Back in normal mode with transmit high the lines sit recessive on mid bias
  a_rec_on_return: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_normal && txd |=> !bus_ctl.dominant && !bus_ctl.term_gnd)
    else $error("bus not recessive on mid bias in normal mode");

  // Bias output stays driven whenever the transceiver is awake
  a_split_active: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !is_sleep |=> !bus_ctl.split_oe_n && !bus_ctl.term_gnd)
    else $error("mid bias not driven while awake");

  // Unused slew code three falls back to the fastest edge rate
  a_slew_default: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ctrl_q[CTRL_SLEW_LSB +: 2] inside {2'b00, 2'b11} |=>
    bus_ctl.slew == CANTRX_SLEW_FAST)
    else $error("slew not fastest for default code");

  // =====================================================================
  // Checks on stuck transmit, interrupts and read port
  // =====================================================================
  // The stuck flag and its status bit rise together at the limit
  a_stuck_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ce && txd_cnt_hit && is_normal && !txd && !txd_dom_q |=>
    txd_dom_q && irq_sts_q[IRQ_TXD_DOM])
    else $error("stuck dominant not flagged at limit");

  // A recessive transmit level releases the stuck lockout at once
  a_stuck_release: assert property (@(posedge clk) disable iff (!rst_n)
    ce && txd_dom_q && txd |=> !txd_dom_q)
    else $error("stuck lockout not released");

  // Interrupt is a registered level of the unmasked status bits
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> irq == |(irq_sts_q & mask_q))
    else $error("interrupt level does not match status and mask");

  // Read data are zero outside the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero without a read");

  // Clock enable low freezes every register; a strobe in that cycle is lost,
  // so software must not rely on accesses made while the block is held
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(ctrl_q) && $stable(irq_sts_q) && $stable(bus_ctl))
    else $error("state changed while clock enable low");

  // =====================================================================
  // Checks on the wake path
  // =====================================================================
  // Low-power output only stands while the mode is sleep
  a_lp_tracks_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !is_sleep |=> !low_power_state)
    else $error("low power shown outside sleep");

  // Wake takes one edge: mode back to normal and low power released together,
  // and the receive pin and bias follow one edge after the state output drops, the driver one edge after that
  sequence s_wake_seen;
    ce && wake_pulse;
  endsequence

  sequence s_normal_back;
    is_normal ##1 !low_power_state;
  endsequence

  a_wake_to_normal: assert property (@(posedge clk) disable iff (!rst_n)
    s_wake_seen |=> s_normal_back)
    else $error("wake did not return to normal mode");

endmodule // cantrx_top

// ==== src/cantrx_wake.sv ====
// Purpose : Bus wake-up pattern detector, single-pulse or three-pulse form
// Assumes : bus_dom is synchronous to clk
// Notes   : Counts only while enabled; restarts when the window expires
`timescale 1ns/100ps
module cantrx_wake
  import cantrx_pkg::*;
#(
  parameter int WINDOW_CYC = WAKE_WINDOW_CYC
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Control
  input  wire logic enable,
  input  wire logic single_sel,
  input  wire logic bus_dom,
  // Result
  output logic      wake_pulse
);

  // =====================================================================
  // Pulse width, pulse count and window
  // =====================================================================
  logic [7:0]  width_q;
  logic [1:0]  count_q;
  logic [24:0] win_q;
  logic        wake_q;

  wire width_sat   = (width_q == 8'hff);
  wire pulse_end   = enable && !bus_dom && (width_q != 8'h00);
  wire pulse_valid = pulse_end && (width_q >= 8'(WAKE_PULSE_MIN_CYC));
  wire single_hit  = enable && single_sel && bus_dom &&
                     (width_q == 8'(WAKE_SINGLE_CYC - 1));
  wire win_run     = (count_q != 2'h0);
  wire win_expired = win_run && (win_q >= 25'(WINDOW_CYC));
  wire third_hit   = enable && !single_sel && pulse_valid &&
                     (count_q == 2'(WAKE_PULSES - 1)) && !win_expired;

  // Width counter saturates so a long dominant level cannot wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      width_q <= 8'h00;
    else if (ce)
      width_q <= (enable && bus_dom) ? (width_sat ? width_q : width_q + 8'h01) : 8'h00;
  end

  // Pulse count with window restart
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= 2'h0;
      win_q   <= 25'h0;
    end
    else if (ce)
    begin
      if (!enable || single_sel || third_hit || win_expired)
      begin
        count_q <= 2'h0;
        win_q   <= 25'h0;
      end
      else
      begin
        if (pulse_valid)
          count_q <= count_q + 2'h1;
        win_q <= win_run || pulse_valid ? win_q + 25'h1 : 25'h0;
      end
    end
  end

  // One-cycle wake pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_q <= 1'b0;
    else if (ce)
      wake_q <= third_hit || single_hit;
  end

  assign wake_pulse = wake_q;

  a_window_restart: assert property (@(posedge clk) disable iff (!rst_n)
    ce && win_expired |=> count_q == 2'h0)
    else $error("wake count not cleared on window expiry");

endmodule // cantrx_wake
